// ### hdl/rcs_reset_cause_status.sv
// Reset-cause status register, watchdog service port and internal reset sequencer.
//
// The register addresses and the AHB-Lite register port were chosen for this implementation.
`timescale 1ns/100ps
module rcs_reset_cause_status
  import rcs_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic resetPinN,
  input wire logic lowVoltage,
  input wire logic illegalOpcode,
  input wire logic stopExec,
  input wire logic bgEntryExec,
  input wire logic illegalAddress,
  output logic chipResetOut,
  output logic [7:0] resetCause,
  output logic irq
);

  rcs_state_t s_q;
  rcs_state_t s_d;

  logic busTake;
  logic mapped;
  logic wdEnabled;
  logic [12:0] wdLimit;
  logic pinActive;
  logic lvActive;
  logic dbgEvt;
  logic wdogEvt;
  logic illegalEvt;
  logic anyEvt;
  logic [1:0] irqSet;
  logic [1:0] irqClr;
  logic [7:0] wrByte;

  always_comb begin
    unique case (s_q.wdSel)
      2'h1: wdLimit = RCS_WD_LIMIT_1;
      2'h2: wdLimit = RCS_WD_LIMIT_2;
      2'h3: wdLimit = RCS_WD_LIMIT_3;
      default: wdLimit = RCS_WD_LIMIT_3;
    endcase
  end

  assign busTake = hsel & htrans[1] & hready;
  assign wrByte = hwdata[7:0];

  always_comb begin
    s_d = s_q;
    irqSet = 2'h0;
    irqClr = 2'h0;
    dbgEvt = 1'b0;
    wdogEvt = 1'b0;

    // Two-stage synchronisers for the reset pin and the low-voltage detector.
    s_d.pinSyncA = resetPinN;
    s_d.pinSyncB = s_q.pinSyncA;
    s_d.lvSyncA = lowVoltage;
    s_d.lvSyncB = s_q.lvSyncA;
    pinActive = ~s_q.pinSyncB;
    lvActive = s_q.lvSyncB;

    wdEnabled = (s_q.wdSel != 2'h0) & ~s_q.inReset;

    // Watchdog counter and its halfway warning.
    if (wdEnabled) begin
      s_d.wdCount = s_q.wdCount + 13'h0001;
      if (s_q.wdCount == wdLimit - 13'h0001) begin
        wdogEvt = 1'b1;
      end
      if (s_q.wdCount == (wdLimit >> 1) - 13'h0001) begin
        irqSet[RCS_IRQ_HALFWAY] = 1'b1;
      end
    end else begin
      s_d.wdCount = 13'h0000;
    end

    // Data phase of a write taken in the previous cycle.
    if (s_q.wrPend) begin
      unique case (s_q.wrAddr)
        RCS_OFF_CAUSE: begin
          if (wdEnabled) begin
            if (wrByte == RCS_SVC_FIRST) begin
              s_d.svcArmed = 1'b1;
            end else if (wrByte == RCS_SVC_SECOND) begin
              if (s_q.svcArmed) begin
                s_d.wdCount = 13'h0000;
                irqSet[RCS_IRQ_SERVICED] = 1'b1;
              end
              s_d.svcArmed = 1'b0;
            end else begin
              wdogEvt = 1'b1;
            end
          end
        end
        RCS_OFF_CTRL: begin
          s_d.wdSel = hwdata[RCS_CTRL_WDSEL_LSB +: 2];
          s_d.lowPowerAllow = hwdata[RCS_CTRL_LOW_POWER_ALLOW];
          s_d.bgDebugAllow = hwdata[RCS_CTRL_BG_DEBUG_ALLOW];
        end
        RCS_OFF_DBGRST: begin
          dbgEvt = hwdata[RCS_DBGRST_BIT] & ~s_q.inReset;
        end
        RCS_OFF_IRQSTAT: begin
          irqClr = hwdata[1:0];
        end
        RCS_OFF_IRQMASK: begin
          s_d.irqMask = hwdata[1:0];
        end
        default: begin
        end
      endcase
    end

    illegalEvt = illegalOpcode
      | (stopExec & ~s_q.lowPowerAllow)
      | (bgEntryExec & ~s_q.bgDebugAllow);
    anyEvt = pinActive | lvActive | dbgEvt | wdogEvt | illegalEvt | illegalAddress;

    // Reset entry captures the cause; during the hold only the pin and low-voltage sources act, and they restart it.
    if (s_q.inReset) begin
      if (pinActive | lvActive) begin
        s_d.holdCount = RCS_RESET_HOLD_CYCLES;
      end else if (s_q.holdCount == 5'h00) begin
        s_d.inReset = 1'b0;
      end else begin
        s_d.holdCount = s_q.holdCount - 5'h01;
      end
    end else if (anyEvt) begin
      s_d.inReset = 1'b1;
      s_d.holdCount = RCS_RESET_HOLD_CYCLES;
      s_d.wdCount = 13'h0000;
      s_d.svcArmed = 1'b0;
      s_d.wdSel = RCS_WDSEL_RST;
      s_d.lowPowerAllow = RCS_LOW_POWER_ALLOW_RST;
      s_d.bgDebugAllow = RCS_BG_DEBUG_ALLOW_RST;
      s_d.flags = 8'h00;
      if (lvActive) begin
        s_d.flags[RCS_BIT_POWER_ON] = s_q.flags[RCS_BIT_POWER_ON];
        s_d.flags[RCS_BIT_LOW_VOLTAGE] = 1'b1;
      end else if (!dbgEvt) begin
        s_d.flags[RCS_BIT_PIN] = pinActive;
        s_d.flags[RCS_BIT_WATCHDOG] = wdogEvt;
        s_d.flags[RCS_BIT_ILLEGAL_OPCODE] = illegalEvt;
        s_d.flags[RCS_BIT_ILLEGAL_ADDRESS] = illegalAddress;
      end
    end

    // Sticky events: a set in the same cycle as a clear wins.
    s_d.irqStatus = (s_q.irqStatus & ~irqClr) | irqSet;
    s_d.irq = |(s_d.irqStatus & s_d.irqMask);

    // Address phase: zero-wait slave, read data taken from the updated state.
    mapped = (haddr[31:5] == 27'h0000000) && (haddr[1:0] == 2'h0) && (haddr[4:2] <= 3'h4);
    s_d.wrPend = busTake & hwrite & mapped;
    s_d.wrAddr = haddr[4:0];
    s_d.ready = 1'b1;
    if (busTake & ~hwrite) begin
      s_d.rdata = 32'h00000000;
      if (mapped) begin
        unique case (haddr[4:0])
          RCS_OFF_CAUSE: s_d.rdata[7:0] = s_d.flags;
          RCS_OFF_CTRL: begin
            s_d.rdata[RCS_CTRL_WDSEL_LSB +: 2] = s_d.wdSel;
            s_d.rdata[RCS_CTRL_LOW_POWER_ALLOW] = s_d.lowPowerAllow;
            s_d.rdata[RCS_CTRL_BG_DEBUG_ALLOW] = s_d.bgDebugAllow;
          end
          RCS_OFF_IRQSTAT: s_d.rdata[1:0] = s_d.irqStatus;
          RCS_OFF_IRQMASK: s_d.rdata[1:0] = s_d.irqMask;
          default: s_d.rdata = 32'h00000000;
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      s_q <= '0;
      s_q.pinSyncA <= 1'b1;
      s_q.pinSyncB <= 1'b1;
      s_q.flags <= RCS_CAUSE_POR_RST;
      s_q.wdSel <= RCS_WDSEL_RST;
      s_q.lowPowerAllow <= RCS_LOW_POWER_ALLOW_RST;
      s_q.bgDebugAllow <= RCS_BG_DEBUG_ALLOW_RST;
      s_q.inReset <= 1'b1;
      s_q.holdCount <= RCS_RESET_HOLD_CYCLES;
      s_q.ready <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign hreadyout = s_q.ready;
  assign hresp = 1'b0;
  assign hrdata = s_q.rdata;
  assign chipResetOut = s_q.inReset;
  assign resetCause = s_q.flags;
  assign irq = s_q.irq;

endmodule : rcs_reset_cause_status

// ### pkg/rcs_pkg.sv
// Constants and state type for the reset-cause status block.
package rcs_pkg;

  // Register byte offsets on the AHB-Lite slave.
  localparam logic [4:0] RCS_OFF_CAUSE = 5'h00;
  localparam logic [4:0] RCS_OFF_CTRL = 5'h04;
  localparam logic [4:0] RCS_OFF_DBGRST = 5'h08;
  localparam logic [4:0] RCS_OFF_IRQSTAT = 5'h0C;
  localparam logic [4:0] RCS_OFF_IRQMASK = 5'h10;

  // Reset-cause flag positions.
  localparam int RCS_BIT_POWER_ON = 7;
  localparam int RCS_BIT_PIN = 6;
  localparam int RCS_BIT_WATCHDOG = 5;
  localparam int RCS_BIT_ILLEGAL_OPCODE = 4;
  localparam int RCS_BIT_ILLEGAL_ADDRESS = 3;
  localparam int RCS_BIT_LOW_VOLTAGE = 1;

  // Control register field positions.
  localparam int RCS_CTRL_WDSEL_LSB = 0;
  localparam int RCS_CTRL_LOW_POWER_ALLOW = 2;
  localparam int RCS_CTRL_BG_DEBUG_ALLOW = 3;
  localparam int RCS_DBGRST_BIT = 0;

  // Interrupt event positions.
  localparam int RCS_IRQ_SERVICED = 0;
  localparam int RCS_IRQ_HALFWAY = 1;

  // Reset values.
  localparam logic [7:0] RCS_CAUSE_POR_RST = 8'h82;
  localparam logic [1:0] RCS_WDSEL_RST = 2'h3;
  localparam logic RCS_LOW_POWER_ALLOW_RST = 1'b0;
  localparam logic RCS_BG_DEBUG_ALLOW_RST = 1'b0;

  // Watchdog service sequence values.
  localparam logic [7:0] RCS_SVC_FIRST = 8'h55;
  localparam logic [7:0] RCS_SVC_SECOND = 8'hAA;

  // Watchdog timeout lengths in clock cycles for select values 1, 2 and 3.
  localparam logic [12:0] RCS_WD_LIMIT_1 = 13'h0020;
  localparam logic [12:0] RCS_WD_LIMIT_2 = 13'h0100;
  localparam logic [12:0] RCS_WD_LIMIT_3 = 13'h1000;

  // Internal reset pulse length.
  localparam int RCS_CLK_PERIOD_NS = 100;
  localparam int RCS_RESET_HOLD_NS = 1000;
  localparam logic [4:0] RCS_RESET_HOLD_CYCLES =
    5'((RCS_RESET_HOLD_NS + RCS_CLK_PERIOD_NS - 1) / RCS_CLK_PERIOD_NS);

  typedef struct packed {
    logic pinSyncA;
    logic pinSyncB;
    logic lvSyncA;
    logic lvSyncB;
    logic [7:0] flags;
    logic [1:0] wdSel;
    logic lowPowerAllow;
    logic bgDebugAllow;
    logic svcArmed;
    logic [12:0] wdCount;
    logic inReset;
    logic [4:0] holdCount;
    logic [1:0] irqStatus;
    logic [1:0] irqMask;
    logic irq;
    logic wrPend;
    logic [4:0] wrAddr;
    logic [31:0] rdata;
    logic ready;
  } rcs_state_t;

endpackage : rcs_pkg

// ### tb/rcs_chk.sv
// Port-level assertions for the reset-cause status block.
`timescale 1ns/100ps
module rcs_chk (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic resetPinN,
  input wire logic lowVoltage,
  input wire logic illegalOpcode,
  input wire logic illegalAddress,
  input wire logic chipResetOut,
  input wire logic [7:0] resetCause
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  sequence wrAt(a, v);
    hsel && htrans[1] && hwrite && haddr == a ##1 hwdata[7:0] == v;
  endsequence
  por_flags_a: assert property ($fell(reset) |-> resetCause == 8'h82) else $error("power-on flags");
  spare_zero_a: assert property (!resetCause[2] && !resetCause[0]) else $error("spare bits");
  flags_hold_a: assert property (!$rose(chipResetOut) |-> $stable(resetCause)) else $error("flags moved");
  opcode_entry_a: assert property (illegalOpcode && !chipResetOut |=> chipResetOut && resetCause == 8'h10)
    else $error("opcode entry");
  addr_entry_a: assert property (illegalAddress && !chipResetOut |=> chipResetOut && resetCause == 8'h08)
    else $error("address entry");
  debug_force_a: assert property (wrAt(32'h8, 8'h01) ##0 !chipResetOut |-> ##[0:2] chipResetOut && resetCause == 8'h00)
    else $error("debug force");
  service_safe_a: assert property ((wrAt(32'h0, 8'h55) or wrAt(32'h0, 8'hAA)) ##0 !chipResetOut |=> !chipResetOut [*3])
    else $error("service reset");
  pin_entry_a: assert property ($fell(resetPinN) ##0 !chipResetOut |-> ##[2:4] chipResetOut && resetCause[6])
    else $error("pin entry");
  volt_entry_a: assert property ($rose(lowVoltage) ##0 !chipResetOut |-> ##[2:4] resetCause[1] && resetCause[6:2] == 5'h00)
    else $error("voltage entry");
endmodule : rcs_chk
bind rcs_reset_cause_status rcs_chk rcs_chk_i (.*);

// ### tb/rcs_core_model.sv
// Core model that reports faulting instructions as one-cycle pulses.
`timescale 1ns/100ps
module rcs_core_model (
  input wire logic go,
  input wire logic [1:0] kind,
  output logic illegalOpcode,
  output logic illegalAddress,
  output logic stopExec,
  output logic bgEntryExec
);
  assign illegalOpcode = go && kind == 2'h0;
  assign illegalAddress = go && kind == 2'h1;
  assign stopExec = go && kind == 2'h2;
  assign bgEntryExec = go && kind == 2'h3;
endmodule : rcs_core_model

// ### tb/reset_cause_status_bench.sv
// Self-checking bench for the reset-cause status block.
`timescale 1ns/100ps
module reset_cause_status_bench;
  import rcs_pkg::*;
  logic clk_sys = 0, reset = 1, hsel = 1, hwrite = 0, resetPinN = 1, lowVoltage = 0, go = 0, rdPend = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata;
  logic [1:0] htrans = 0, kind = 0;
  logic [2:0] hsize = 3'h2;
  logic hready, hreadyout, hresp, illegalOpcode, stopExec, bgEntryExec, illegalAddress, chipResetOut, irq;
  logic [7:0] resetCause, v;
  logic [31:0] expQ[$];
  int miscompares = 0, n_checks = 0;
  assign hready = hreadyout;
  always #50 clk_sys = ~clk_sys;
  rcs_reset_cause_status rcs_reset_cause_status_i (.*);
  rcs_core_model rcs_core_model_i (.*);
  task automatic cmp(input string what, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask : cmp
  task automatic final_report;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : final_report
  task automatic req(input logic [31:0] a, input logic w);
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
  endtask : req
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    req(a, 1'b1);
    hwdata <= d;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
  endtask : wr
  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    expQ.push_back(e);
    req(a, 1'b0);
    rdPend <= 1;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    rdPend <= 0;
    cmp("hresp", 32'h0, {31'h0, hresp});
  endtask : rd
  always @(posedge clk_sys) if (rdPend) cmp("hrdata", expQ.pop_front(), hrdata);
  // Waits past the input synchronisers, then until the internal reset ends.
  task automatic settle;
    repeat (4) @(posedge clk_sys);
    for (int i = 0; i < 60 && chipResetOut !== 1'b0; i++) @(posedge clk_sys);
  endtask : settle
  task automatic fire(input logic [1:0] k);
    kind <= k;
    go <= 1;
    @(posedge clk_sys);
    go <= 0;
    settle;
  endtask : fire
  initial begin
    #3000000;
    miscompares++;
    final_report;
  end
  initial begin
    void'($urandom(3));
    repeat (10) @(posedge clk_sys);
    reset <= 0;
    settle;
    rd(32'h0, 32'h82);
    rd(32'h0, 32'h82);
    cmp("resetCause", 32'h82, {24'h0, resetCause});
    cmp("chipResetOut", 32'h0, {31'h0, chipResetOut});
    rd(32'h4, 32'h3);
    rd(32'h14, 32'h0);
    $display("power-on test done");
    for (int k = 0; k < 4; k++) begin
      fire(k[1:0]);
      rd(32'h0, (k == 1) ? 32'h08 : 32'h10);
    end
    wr(32'h4, 32'hF);
    fire(2'h2);
    fire(2'h3);
    rd(32'h4, 32'hF);
    $display("source test done");
    wr(32'h10, 32'h1);
    wr(32'h0, 32'h55);
    wr(32'h0, 32'hAA);
    rd(32'hC, 32'h1);
    cmp("irq", 32'h1, {31'h0, irq});
    wr(32'h10, 32'h0);
    repeat (2) @(posedge clk_sys);
    cmp("irq", 32'h0, {31'h0, irq});
    wr(32'hC, 32'h1);
    rd(32'hC, 32'h0);
    rd(32'h0, 32'h10);
    $display("service test done");
    v = 8'($urandom);
    if (v == 8'h55 || v == 8'hAA) v = 8'h01;
    wr(32'h0, {24'h0, v});
    settle;
    rd(32'h0, 32'h20);
    wr(32'h4, 32'h1);
    repeat (40) @(posedge clk_sys);
    settle;
    rd(32'h4, 32'h3);
    rd(32'h0, 32'h20);
    cmp("resetCause", 32'h20, {24'h0, resetCause});
    wr(32'h4, 32'h0);
    repeat (40) @(posedge clk_sys);
    wr(32'h0, 32'h12);
    settle;
    rd(32'h4, 32'h0);
    $display("watchdog test done");
    wr(32'h8, 32'h1);
    settle;
    rd(32'h0, 32'h0);
    resetPinN <= 0;
    repeat (5) @(posedge clk_sys);
    resetPinN <= 1;
    settle;
    rd(32'h0, 32'h40);
    lowVoltage <= 1;
    repeat (5) @(posedge clk_sys);
    lowVoltage <= 0;
    settle;
    rd(32'h0, 32'h02);
    $display("external reset test done");
    final_report;
  end
endmodule : reset_cause_status_bench
